/* pkg/eeprom_host_pkg.sv */
// shared constants and types for the parallel eeprom page-write host
package eeprom_host_pkg;

  // ----------------------------------------------------------------
  // clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WP_NS = 250;     // write strobe low, least
  localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_NS = 10;      // data hold after strobe rise, least
  localparam int DH_CYC = (DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_NS = 250;    // read access, wait at least this
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DF_NS = 50;      // output float after read, least wait
  localparam int DF_CYC = (DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLC_MIN_NS = 1000; // byte load cycle, least
  localparam int BLC_MIN_CYC =
    (BLC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLC_MAX_US = 30;   // byte load cycle, most
  localparam int BLC_MAX_CYC = (BLC_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int BL_US = 100;       // byte load window
  localparam int BL_CYC = (BL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DW_NS = 250;       // write start time
  localparam int DW_CYC = (DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_MS = 15;        // write cycle time, most
  localparam int WC_CYC = (WC_MS * 1000000) / CLK_PERIOD_NS;
  localparam int RP_US = 100;       // reset protect time
  localparam int RP_CYC = (RP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int PAGE_LSB = 7;
  localparam logic [7:0] PAGE_BYTES = 8'h80;
  typedef logic [ADDR_W-1:0] addr_type;
  typedef logic [ADDR_W-PAGE_LSB-1:0] page_type;

  // ----------------------------------------------------------------
  // commands and lock code defaults (arbitrary neutral values)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LOCK, OP_UNLOCK} op_type;
  localparam logic [2:0][16:0] LOCK_ADDR_DEF =
    {17'h00003, 17'h00002, 17'h00001};
  localparam logic [2:0][7:0] LOCK_DATA_DEF = {8'h03, 8'h02, 8'h01};
  localparam logic [5:0][16:0] UNLOCK_ADDR_DEF =
    {17'h00006, 17'h00005, 17'h00004, 17'h00003, 17'h00002, 17'h00001};
  localparam logic [5:0][7:0] UNLOCK_DATA_DEF =
    {8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11};

endpackage

/* pkg/eeprom_cycle_if.sv */
// one pin-level bus cycle: request from the controller, answer back
`timescale 1ns/10ps
interface eeprom_cycle_if;
  import eeprom_host_pkg::*;
  logic req;
  logic wr;
  addr_type addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctrl (output req, wr, addr, wdata, input done, rdata);
  modport seq (input req, wr, addr, wdata, output done, rdata);
endinterface

/* rtl/eeprom_pin_seq.sv */
// drives one write or read cycle on the eeprom pins
`timescale 1ns/10ps
module eeprom_pin_seq
  import eeprom_host_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // cycle request
  eeprom_cycle_if.seq cyc,
  // eeprom pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output addr_type addr_o,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  input wire logic [7:0] data_i
);
  import eeprom_host_pkg::*;

  localparam int WH_LEN = BLC_MIN_CYC - WP_CYC;
  localparam logic [7:0] WP_LIM = 8'(WP_CYC - 1);
  localparam logic [7:0] WH_LIM = 8'(WH_LEN - 1);
  localparam logic [7:0] REL_AT = 8'(WH_LEN - 1 - DH_CYC);
  localparam logic [7:0] ACC_LIM = 8'(ACC_CYC);
  localparam logic [7:0] DF_LIM = 8'(DF_CYC - 1);

  typedef enum logic [2:0] {S_IDLE, S_WLOW, S_WHIGH, S_RD, S_FLOAT}
    sstate_type;
  typedef struct packed {
    sstate_type st;
    logic [7:0] cnt;
    addr_type addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic doe_n;
    logic done;
  } seq_type;

  seq_type r;
  seq_type n;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  // a write cycle always spans the least byte load cycle, so back to
  // back loads never come closer than the device allows
  always_comb begin
    n = r;
    n.done = 1'b0;
    case (r.st)
      S_IDLE: begin
        if (cyc.req) begin
          n.addr = cyc.addr;
          n.wdata = cyc.wdata;
          n.ce_n = 1'b0;
          if (cyc.wr) begin
            n.oe_n = 1'b1;
            n.we_n = 1'b0;    // address taken by device on this fall
            n.doe_n = 1'b0;
            n.cnt = WP_LIM;
            n.st = S_WLOW;
          end else begin
            n.oe_n = 1'b0;
            n.doe_n = 1'b1;
            n.cnt = ACC_LIM;
            n.st = S_RD;
          end
        end
      end
      S_WLOW: begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h00) begin
          n.we_n = 1'b1;      // data taken by device on this rise
          n.cnt = WH_LIM;
          n.st = S_WHIGH;
        end
      end
      S_WHIGH: begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == REL_AT) begin
          n.ce_n = 1'b1;
          n.doe_n = 1'b1;
        end
        if (r.cnt == 8'h00) begin
          n.done = 1'b1;
          n.st = S_IDLE;
        end
      end
      S_RD: begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h00) begin
          n.rdata = data_i;
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.cnt = DF_LIM;
          n.st = S_FLOAT;
        end
      end
      S_FLOAT: begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h00) begin
          n.done = 1'b1;
          n.st = S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  // idle pins: deselected, strobes high, data bus released
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
      r.ce_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.doe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign ce_n_o = r.ce_n;
  assign oe_n_o = r.oe_n;
  assign we_n_o = r.we_n;
  assign addr_o = r.addr;
  assign data_o = r.wdata;
  assign data_oe_n_o = r.doe_n;
  assign cyc.done = r.done;
  assign cyc.rdata = r.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_strobe_width: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(r.we_n) |-> !r.we_n [*8] ##18 r.we_n)
    else $error("write strobe width wrong");
  a_data_held: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(r.we_n) |-> !r.doe_n && $stable(r.wdata))
    else $error("data released at strobe rise");

endmodule

/* rtl/eeprom_page_host.sv */
// host controller for a byte-wide parallel eeprom with page write
// How it works
// - next byte load starts within 30 us
// - page address stays fixed during page load
// - without status, wait full 15 ms
// - polling may begin after 250 ns
// - poll reads keep one fixed address
// - keep inhibit high, low at power ramps
// - in lock mode, code precedes the first byte of each page load
`timescale 1ns/10ps
module eeprom_page_host
  import eeprom_host_pkg::*;
#(
  parameter int BL_CYC_P = BL_CYC,
  parameter int WC_CYC_P = WC_CYC,
  parameter int RP_CYC_P = RP_CYC,
  parameter logic [2:0][16:0] LOCK_ADDR = LOCK_ADDR_DEF,
  parameter logic [2:0][7:0] LOCK_DATA = LOCK_DATA_DEF,
  parameter logic [5:0][16:0] UNLOCK_ADDR = UNLOCK_ADDR_DEF,
  parameter logic [5:0][7:0] UNLOCK_DATA = UNLOCK_DATA_DEF
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire eeprom_host_pkg::op_type cmd_op_i,
  input wire eeprom_host_pkg::addr_type cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_last_i,
  // answer port
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_err_o,
  output logic busy_o,
  output logic lock_on_o,
  // eeprom pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output eeprom_host_pkg::addr_type addr_o,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  input wire logic [7:0] data_i,
  input wire logic rdy_busy_i,
  output logic hard_inhibit_n_o
);
  import eeprom_host_pkg::*;

  localparam logic [20:0] RP_LIM = 21'(RP_CYC_P - 1);
  localparam int GAP_MAX = BLC_MAX_CYC - BLC_MIN_CYC - 4;
  localparam logic [20:0] GAP_LIM = 21'(GAP_MAX);
  localparam int SETTLE_N = BL_CYC_P + DW_CYC;
  localparam logic [20:0] SETTLE_LIM = 21'(SETTLE_N);
  localparam logic [20:0] WC_LIM = 21'(WC_CYC_P);

  typedef enum logic [3:0] {M_INHIBIT, M_IDLE, M_CODE, M_LOAD, M_GAP,
    M_SETTLE, M_POLL1, M_POLL2, M_READ} mstate_type;
  typedef struct packed {
    mstate_type st;
    logic [20:0] cnt;
    logic [20:0] wc;
    logic [2:0] idx;
    logic [2:0] len;
    logic unl;
    logic has_data;
    logic set_lock;
    page_type page;
    logic [7:0] nbytes;
    logic close;
    addr_type waddr;
    logic [7:0] wdata;
    logic prev6;
    logic inh_n;
    logic lock_on;
    logic rsp_v;
    logic [7:0] rsp_d;
    logic rsp_e;
    logic req;
    logic wr;
    addr_type caddr;
    logic [7:0] cdata;
  } main_type;

  main_type r;
  main_type n;
  eeprom_cycle_if cyc ();

  // ----------------------------------------------------------------
  // lock code lookup
  // ----------------------------------------------------------------
  // returns {address, data} of code word idx of either sequence
  function automatic logic [24:0] code_word(input logic [2:0] idx,
                                            input logic unl);
    logic [24:0] w;
    w = '0;
    if (unl) begin
      w = {UNLOCK_ADDR[idx], UNLOCK_DATA[idx]};
    end else if (idx < 3'h3) begin
      w = {LOCK_ADDR[idx[1:0]], LOCK_DATA[idx[1:0]]};
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  // a further byte joins the open page only if it shares its page
  always_comb begin
    cmd_ready_o = 1'b0;
    if (r.st == M_IDLE) begin
      cmd_ready_o = 1'b1;
    end else if (r.st == M_GAP && cmd_op_i == OP_WRITE) begin
      cmd_ready_o = (cmd_addr_i[ADDR_W-1:PAGE_LSB] == r.page) &&
                    (r.nbytes < PAGE_BYTES);
    end
  end

  // ----------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.req = 1'b0;
    n.rsp_v = 1'b0;
    case (r.st)
      M_INHIBIT: begin
        n.inh_n = 1'b1;     // held high from here on
        n.cnt = r.cnt + 21'h1;
        if (r.cnt == RP_LIM) begin
          n.cnt = '0;
          n.st = M_IDLE;
        end
      end
      M_IDLE: begin
        if (cmd_valid_i) begin
          n.waddr = cmd_addr_i;
          n.wdata = cmd_data_i;
          n.close = cmd_last_i;
          n.page = cmd_addr_i[ADDR_W-1:PAGE_LSB];
          n.nbytes = 8'h01;
          n.idx = '0;
          n.wc = '0;
          n.caddr = cmd_addr_i;
          n.cdata = cmd_data_i;
          n.req = 1'b1;
          n.wr = 1'b1;
          n.unl = 1'b0;
          n.len = 3'h3;
          n.has_data = 1'b1;
          n.set_lock = 1'b0;
          case (cmd_op_i)
            OP_READ: begin
              n.wr = 1'b0;
              n.st = M_READ;
            end
            OP_WRITE: begin
              n.st = r.lock_on ? M_CODE : M_LOAD;
            end
            OP_LOCK: begin
              n.set_lock = 1'b1;
              n.st = M_CODE;
            end
            default: begin
              n.unl = 1'b1;
              n.len = 3'h6;
              n.has_data = 1'b0;
              n.st = M_CODE;
            end
          endcase
          if (n.st == M_CODE) begin
            {n.caddr, n.cdata} = code_word(3'h0, n.unl);
          end
        end
      end
      M_CODE: begin
        if (cyc.done) begin
          if (r.idx == r.len - 3'h1) begin
            if (r.has_data) begin
              n.req = 1'b1; // data follows its code directly
              n.caddr = r.waddr;
              n.cdata = r.wdata;
              n.lock_on = r.lock_on | r.set_lock;
              n.st = M_LOAD;
            end else begin
              n.lock_on = 1'b0;
              n.waddr = r.caddr;
              n.wdata = r.cdata;
              n.cnt = '0;
              n.st = M_SETTLE;
            end
          end else begin
            n.idx = r.idx + 3'h1;
            n.req = 1'b1;
            {n.caddr, n.cdata} = code_word(n.idx, r.unl);
          end
        end
      end
      M_LOAD: begin
        if (cyc.done) begin
          n.cnt = '0;
          if (r.close || r.nbytes == PAGE_BYTES) begin
            n.st = M_SETTLE;
          end else begin
            n.st = M_GAP;
          end
        end
      end
      M_GAP: begin
        // strobe fell a full load cycle ago, so the gap limit is short
        n.cnt = r.cnt + 21'h1;
        if (cmd_valid_i && cmd_ready_o) begin
          n.waddr = cmd_addr_i;
          n.wdata = cmd_data_i;
          n.close = cmd_last_i;
          n.nbytes = r.nbytes + 8'h01;
          n.req = 1'b1;
          n.wr = 1'b1;
          n.caddr = cmd_addr_i;
          n.cdata = cmd_data_i;
          n.st = M_LOAD;
        end else if (cmd_valid_i || r.cnt == GAP_LIM) begin
          n.cnt = '0;
          n.st = M_SETTLE;
        end
      end
      M_SETTLE: begin
        // idle long enough for the device to start on its own
        n.cnt = r.cnt + 21'h1;
        n.wc = r.wc + 21'h1;
        if (r.cnt == SETTLE_LIM) begin
          n.req = 1'b1;
          n.wr = 1'b0;
          n.caddr = r.waddr;
          n.st = M_POLL1;
        end
      end
      M_POLL1: begin
        n.wc = r.wc + 21'h1;
        if (cyc.done) begin
          n.prev6 = cyc.rdata[6];
          n.req = 1'b1;
          n.st = M_POLL2;
        end
      end
      M_POLL2: begin
        n.wc = r.wc + 21'h1;
        if (cyc.done) begin
          // ready when bit six stops, bit seven matches written data, pin released
          if (cyc.rdata[6] == r.prev6 &&
              cyc.rdata[7] == r.wdata[7] &&
              rdy_busy_i) begin
            n.rsp_v = 1'b1;
            n.rsp_d = cyc.rdata;
            n.rsp_e = 1'b0;
            n.st = M_IDLE;
          end else if (r.wc >= WC_LIM) begin
            n.rsp_v = 1'b1;
            n.rsp_d = cyc.rdata;
            n.rsp_e = 1'b1;
            n.st = M_IDLE;
          end else begin
            n.prev6 = cyc.rdata[6];
            n.req = 1'b1;
          end
        end
      end
      M_READ: begin
        if (cyc.done) begin
          n.rsp_v = 1'b1;
          n.rsp_d = cyc.rdata;
          n.rsp_e = 1'b0;
          n.st = M_IDLE;
        end
      end
      default: n.st = M_IDLE;
    endcase
  end

  // reset zeroes all: first state is the inhibit hold, lock off
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign cyc.req = r.req;
  assign cyc.wr = r.wr;
  assign cyc.addr = r.caddr;
  assign cyc.wdata = r.cdata;
  assign rsp_valid_o = r.rsp_v;
  assign rsp_data_o = r.rsp_d;
  assign rsp_err_o = r.rsp_e;
  assign busy_o = (r.st != M_IDLE);
  assign lock_on_o = r.lock_on;
  assign hard_inhibit_n_o = r.inh_n;

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  eeprom_pin_seq u_seq (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .cyc(cyc.seq),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .addr_o(addr_o),
    .data_o(data_o),
    .data_oe_n_o(data_oe_n_o),
    .data_i(data_i)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int SETTLE_MIN = SETTLE_N;
  sequence s_poll_req;
    r.req && !r.wr && (r.st == M_POLL1 || r.st == M_POLL2);
  endsequence
  sequence s_read_done;
    r.st == M_READ && cyc.done;
  endsequence

  a_gap_limit: assert property (@(posedge clk_i) disable iff (srst_i)
    r.st == M_GAP |-> r.cnt <= GAP_LIM)
    else $error("byte load gap too long");
  a_page_fixed: assert property (@(posedge clk_i) disable iff (srst_i)
    r.req && r.wr && r.st == M_LOAD |->
      r.caddr[ADDR_W-1:PAGE_LSB] == r.page)
    else $error("page address changed in page load");
  a_wc_bound: assert property (@(posedge clk_i) disable iff (srst_i)
    r.wc <= WC_LIM + 21'h40)
    else $error("write cycle wait ran past limit");
  a_poll_wait: assert property (@(posedge clk_i) disable iff (srst_i)
    s_poll_req |-> r.wc >= 21'(SETTLE_MIN))
    else $error("poll read before write start time");
  a_poll_addr: assert property (@(posedge clk_i) disable iff (srst_i)
    s_poll_req |-> r.caddr == r.waddr ##1 !r.req [*3])
    else $error("poll address moved");
  a_inhibit_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    r.st != M_INHIBIT |-> r.inh_n && $stable(r.inh_n))
    else $error("inhibit dropped outside reset");
  a_code_first: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(r.st == M_LOAD) && r.nbytes == 8'h01 && r.lock_on |->
      $past(r.st == M_CODE))
    else $error("locked write without code");
  a_code_word: assert property (@(posedge clk_i) disable iff (srst_i)
    r.req && r.st == M_CODE && !r.unl |->
      r.cdata == LOCK_DATA[r.idx[1:0]] ##1 r.st == M_CODE)
    else $error("lock code word wrong");
  a_read_answer: assert property (@(posedge clk_i) disable iff (srst_i)
    s_read_done |=> r.rsp_v && r.rsp_d == $past(cyc.rdata) ##1 !r.rsp_v)
    else $error("read answer missing");

endmodule

/* test/eeprom_dev_model.sv */
// behavioural model of the page-write eeprom facing the host
`timescale 1ns/10ps
module eeprom_dev_model
  import eeprom_host_pkg::*;
#(
  parameter int BL_P = 300
)(
  // pins from the host
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire eeprom_host_pkg::addr_type addr_i,
  input wire logic [7:0] din_i,
  input wire logic inh_n_i,
  // programming time in cycles, set by the bench
  input wire logic [31:0] prog_i,
  // pins to the host
  output logic [7:0] dq_o,
  output logic den_o,
  output logic rb_drv_o
);
  import eeprom_host_pkg::*;
  logic [7:0] mem [int];
  addr_type la [$];
  logic [7:0] ld [$];
  addr_type al;
  logic [7:0] last = 8'h00;
  logic we_d = 1, rd_d = 0, lock = 0, busy = 0, tog = 1, ldg = 0;
  logic m3, m6;
  int idle = 0, pc = 0, wlo = 0;
  initial dq_o = 8'h00;
  initial den_o = 0;
  // loading or programming holds ready/busy low
  assign rb_drv_o = busy || ldg;
  // pins are sampled mid-cycle so the host's edges never race this
  // model; a strobe seen low for under three samples counts as noise
  always @(negedge clk_i) begin
    if (!inh_n_i) begin
      busy = 0; ldg = 0; la = {}; ld = {}; den_o = 0;
    end else begin
      if (!ce_n_i && we_d && !we_n_i) al = addr_i;
      if (!ce_n_i && !we_d && we_n_i && !busy && wlo > 2) begin
        la.push_back(al); ld.push_back(din_i); last = din_i;
        ldg = 1; idle = 0;
      end
      if (ldg && we_n_i) idle++;
      if (ldg && idle >= BL_P) begin
        ldg = 0; busy = 1; pc = 0; tog = 1;
        m3 = la.size() > 3;
        m6 = la.size() >= 6;
        for (int k = 0; k < 6; k++) begin
          if (la[k] !== UNLOCK_ADDR_DEF[k]) m6 = 0;
          if (ld[k] !== UNLOCK_DATA_DEF[k]) m6 = 0;
          if (k < 3 && la[k] !== LOCK_ADDR_DEF[k]) m3 = 0;
          if (k < 3 && ld[k] !== LOCK_DATA_DEF[k]) m3 = 0;
        end
        if (m6) begin
          lock = 0; la = {};
        end else if (m3) begin
          lock = 1; la = la[3:$]; ld = ld[3:$];
        end else if (lock) la = {};
      end
      if (busy) pc++;
      if (busy && pc >= prog_i) begin
        busy = 0;
        foreach (la[i]) mem[la[i]] = ld[i];
        la = {}; ld = {};
      end
      den_o = !ce_n_i && !oe_n_i && we_n_i;
      if (den_o) dq_o = busy ? {~last[7], tog, last[5:0]} :
        (mem.exists(addr_i) ? mem[addr_i] : 8'hff);
      if (rd_d && !den_o && busy) tog = ~tog;
      rd_d = den_o;
    end
    wlo = (!ce_n_i && !we_n_i) ? wlo + 1 : 0;
    we_d = we_n_i;
  end
endmodule

/* test/eeprom_page_host_tb.sv */
// self-checking bench for the eeprom page-write host
`timescale 1ns/10ps
module eeprom_page_host_tb;
  import eeprom_host_pkg::*;
  typedef struct packed {logic rd; logic e; logic [7:0] d;} exp_type;
  localparam int WCP = 2000;
  logic clk_i = 0, srst_i = 1, cmd_valid_i = 0, cmd_last_i = 0;
  op_type cmd_op_i = OP_READ;
  addr_type cmd_addr_i = 17'h00000, addr_o;
  logic [7:0] cmd_data_i = 8'h00, rsp_data_o, data_o, dq, data_i;
  logic [7:0] held = 8'h00;
  logic cmd_ready_o, rsp_valid_o, rsp_err_o, busy_o, lock_on_o, den, rb;
  logic ce_n_o, oe_n_o, we_n_o, data_oe_n_o, hard_inhibit_n_o;
  int prog = 100, n_mismatch = 0, checks_done = 0, cyc = 0;
  exp_type q [$];
  exp_type e;
  logic [7:0] mir [int];
  always #5 clk_i = ~clk_i;
  eeprom_page_host #(.BL_CYC_P(300), .WC_CYC_P(WCP), .RP_CYC_P(5)) uut (
    .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
    .cmd_last_i(cmd_last_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .busy_o(busy_o),
    .lock_on_o(lock_on_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
    .we_n_o(we_n_o), .addr_o(addr_o), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .data_i(data_i), .rdy_busy_i(~rb),
    .hard_inhibit_n_o(hard_inhibit_n_o));
  eeprom_dev_model #(.BL_P(300)) dev (
    .clk_i(clk_i), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .addr_i(addr_o), .din_i(data_o), .inh_n_i(hard_inhibit_n_o),
    .prog_i(prog), .dq_o(dq), .den_o(den), .rb_drv_o(rb));
  // a floating bus shows the inverse of its last level, never a hold
  assign data_i = den ? dq : (!data_oe_n_o ? data_o : ~held);
  always @(posedge clk_i) held <= data_i;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // cycle ceiling well above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // take the oldest note whenever an answer appears
  always @(posedge clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (q.size() == 0) check(8'h01, 8'h00);
      else begin
        e = q.pop_front();
        check({7'h00, rsp_err_o}, {7'h00, e.e});
        if (e.rd) check(rsp_data_o, e.d);
      end
    end
  end
  function automatic logic [7:0] mv(input addr_type a);
    return mir.exists(a) ? mir[a] : 8'hff;
  endfunction
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  task automatic send(input op_type op, input addr_type a,
                      input logic [7:0] d, input logic last);
    int k;
    cmd_valid_i = 1; cmd_op_i = op; cmd_addr_i = a;
    cmd_data_i = d; cmd_last_i = last;
    if (op == OP_READ) q.push_back({1'b1, 1'b0, mv(a)});
    else if (last) q.push_back({1'b0, prog > WCP, 8'h00});
    if (op == OP_WRITE || op == OP_LOCK) mir[a] = d;
    k = 0;
    @(posedge clk_i);
    while (cmd_ready_o !== 1'b1 && k < 30000) begin
      k++;
      @(posedge clk_i);
    end
    if (k == 30000) n_mismatch++; // a command never taken fails the run
    #1;
  endtask
  // valid drops here only, so a held command is never taken twice
  task automatic settle();
    int k;
    cmd_valid_i = 0;
    k = 0;
    while ((q.size() > 0 || busy_o !== 1'b0 || rb) && k < 40000) begin
      k++;
      @(posedge clk_i);
    end
    if (k == 40000) n_mismatch++; // a hung answer fails the run
    #1;
  endtask
  initial begin
    int p;
    int lens [3];
    void'($urandom(96095));
    lens = '{1, 128, 2 + $urandom % 126};
    repeat (12) @(posedge clk_i);
    #1 srst_i = 0;
    check({7'h00, lock_on_o}, 8'h00);
    check({6'h00, busy_o, hard_inhibit_n_o}, 8'h02);
    foreach (lens[t]) begin
      p = 1 + $urandom % 1022;
      for (int i = 0; i < lens[t]; i++)
        send(OP_WRITE, {p[9:0], i[6:0]}, 8'($urandom), i == lens[t] - 1);
      for (int i = 0; i < lens[t]; i++)
        send(OP_READ, {p[9:0], i[6:0]}, 8'h00, 1'b1);
      settle();
      $display("page test of %0d bytes done", lens[t]);
    end
    p = 1 + $urandom % 1022;
    send(OP_WRITE, {p[9:0], 7'h05}, 8'h5a, 1'b0);
    q.push_back({1'b0, 1'b0, 8'h00});
    send(OP_WRITE, {p[9:0] + 10'h001, 7'h05}, 8'ha5, 1'b1);
    send(OP_READ, {p[9:0], 7'h05}, 8'h00, 1'b1);
    send(OP_READ, {p[9:0] + 10'h001, 7'h05}, 8'h00, 1'b1);
    settle();
    $display("page change test done");
    check({7'h00, hard_inhibit_n_o}, 8'h01);
    foreach (lens[t]) begin
      if (t < 2) begin
        prog = t == 0 ? 1500 : 3000;
        send(OP_WRITE, {p[9:0], 7'h20}, 8'($urandom), 1'b1);
        if (prog < WCP) send(OP_READ, {p[9:0], 7'h20}, 8'h00, 1'b1);
        settle();
      end
    end
    prog = 100;
    $display("slow device test done");
    send(OP_WRITE, UNLOCK_ADDR_DEF[5], UNLOCK_DATA_DEF[5], 1'b1);
    send(OP_LOCK, {p[9:0], 7'h10}, 8'hc3, 1'b1);
    settle();
    check({7'h00, lock_on_o}, 8'h01);
    send(OP_WRITE, {p[9:0], 7'h11}, 8'h3c, 1'b1);
    send(OP_UNLOCK, 17'h00000, 8'h00, 1'b1);
    settle();
    check({7'h00, lock_on_o}, 8'h00);
    send(OP_WRITE, {p[9:0], 7'h12}, 8'h96, 1'b1);
    for (int i = 0; i < 3; i++)
      send(OP_READ, {p[9:0], 7'h10 + 7'(i)}, 8'h00, 1'b1);
    for (int i = 0; i < 6; i++)
      send(OP_READ, UNLOCK_ADDR_DEF[i], 8'h00, 1'b1);
    settle();
    $display("write lock test done");
    complete_run();
  end
endmodule
